// File: rtl/rxsw_offset_cancel.sv
// Purpose: one-shot receiver offset cancellation sequencer
// Assumes: i_reset is the power-up reset of the channel
// Notes: reconfiguration reset abandons a run but never repeats a finished one
`timescale 1ns/1ns
`default_nettype none
module rxsw_offset_cancel #(
  parameter int unsigned CAL_CYCLES = 64
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  input  wire logic i_clk_en,
  input  wire logic i_reconfig_reset,
  output logic      o_disconnect,
  output logic      o_busy,
  output logic      o_done,
  output logic      o_start
);

  localparam int unsigned CW = $clog2(CAL_CYCLES + 1);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);

  initial begin
    if (CAL_CYCLES < 1) $error("CAL_CYCLES must be at least one");
  end

  rxsw_pkg::rxsw_oc_state_t state_reg;
  logic [CW-1:0]            cnt_reg;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= rxsw_pkg::RXSW_OC_WAIT;
      cnt_reg   <= '0;
    end else if (i_clk_en) begin
      unique case (state_reg)
        rxsw_pkg::RXSW_OC_WAIT: begin
          cnt_reg <= '0;
          if (!i_reconfig_reset) state_reg <= rxsw_pkg::RXSW_OC_DISC;
        end
        rxsw_pkg::RXSW_OC_DISC: begin
          if (i_reconfig_reset) state_reg <= rxsw_pkg::RXSW_OC_WAIT;
          else state_reg <= rxsw_pkg::RXSW_OC_CAL;
        end
        rxsw_pkg::RXSW_OC_CAL: begin
          if (i_reconfig_reset) begin
            state_reg <= rxsw_pkg::RXSW_OC_WAIT;
          end else if (cnt_reg == CAL_LAST) begin
            state_reg <= rxsw_pkg::RXSW_OC_DONE;
          end else begin
            cnt_reg <= cnt_reg + CW'(1);
          end
        end
        rxsw_pkg::RXSW_OC_DONE: begin
          state_reg <= rxsw_pkg::RXSW_OC_DONE;
        end
        default: begin
          state_reg <= rxsw_pkg::RXSW_OC_WAIT;
        end
      endcase
    end
  end

  assign o_start      = (state_reg == rxsw_pkg::RXSW_OC_DISC);
  assign o_disconnect = (state_reg == rxsw_pkg::RXSW_OC_DISC) ||
                        (state_reg == rxsw_pkg::RXSW_OC_CAL);
  assign o_busy       = o_disconnect;
  assign o_done       = (state_reg == rxsw_pkg::RXSW_OC_DONE);

endmodule // rxsw_offset_cancel
`default_nettype wire

// File: rtl/rxsw_pkg.sv
// Purpose: shared constants and types of the receive status word block
// Assumes: 16-bit slices packed into a 32-bit word, APB register access
// Notes: register offsets are byte addresses on a 32-bit APB bus
package rxsw_pkg;

  localparam int unsigned SLICE_W      = 16;
  localparam int unsigned RAW_W        = 10;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned PIPE_W       = 2;
  localparam int unsigned APB_AW       = 8;
  localparam int unsigned CNT_W        = 16;

  // slice field positions
  localparam int unsigned POS_DATA_LSB = 0;
  localparam int unsigned POS_CTRL     = 8;
  localparam int unsigned POS_CODEERR  = 9;
  localparam int unsigned POS_SYNC     = 10;
  localparam int unsigned POS_DISPERR  = 11;
  localparam int unsigned POS_PATDET   = 12;
  localparam int unsigned POS_RMDEL    = 13;
  localparam int unsigned POS_RMINS    = 14;
  localparam int unsigned POS_PIPE_LSB = 13;
  localparam int unsigned POS_RDISP    = 15;

  // register byte offsets
  localparam logic [APB_AW-1:0] OFS_CTRL    = 8'h00;
  localparam logic [APB_AW-1:0] OFS_STATUS  = 8'h04;
  localparam logic [APB_AW-1:0] OFS_RCFGOUT = 8'h08;
  localparam logic [APB_AW-1:0] OFS_RCFGIN  = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_RMCNT   = 8'h10;
  localparam logic [APB_AW-1:0] OFS_LIVE    = 8'h14;

  // control register fields
  localparam int unsigned CTRL_MODE10  = 0;
  localparam int unsigned CTRL_PIPE    = 1;
  localparam int unsigned CTRL_ENABLE  = 2;
  localparam int unsigned CTRL_W       = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h4;

  // status register fields
  localparam int unsigned STS_OC_DONE  = 0;
  localparam int unsigned STS_OC_BUSY  = 1;
  localparam int unsigned STS_PD_VIOL  = 2;
  localparam int unsigned STS_CODE_ERR = 3;
  localparam int unsigned STS_SYNC_LOST = 4;

  // rate-match counter register halves
  localparam int unsigned RMCNT_INS_LSB = 0;
  localparam int unsigned RMCNT_DEL_LSB = 16;

  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  typedef enum logic [3:0] {
    RXSW_OC_WAIT = 4'b0001,
    RXSW_OC_DISC = 4'b0010,
    RXSW_OC_CAL  = 4'b0100,
    RXSW_OC_DONE = 4'b1000
  } rxsw_oc_state_t;

endpackage

// File: rtl/rxsw_slice_pack.sv
// Purpose: packs one receive slice into its 16-bit field layout
// Assumes: all inputs belong to the same received code group
// Notes: purely combinational, registered by the caller
`timescale 1ns/1ns
`default_nettype none
module rxsw_slice_pack (
  input  wire logic                                i_mode10,
  input  wire logic                                i_pipe,
  input  wire logic [rxsw_pkg::RAW_W-1:0]          i_data,
  input  wire logic                                i_ctrl,
  input  wire logic                                i_code_err,
  input  wire logic                                i_sync,
  input  wire logic                                i_disp_err,
  input  wire logic                                i_pat_det,
  input  wire logic                                i_rm_del,
  input  wire logic                                i_rm_ins,
  input  wire logic [rxsw_pkg::PIPE_W-1:0]         i_pipe_status,
  input  wire logic                                i_run_disp,
  output logic      [rxsw_pkg::SLICE_W-1:0]        o_slice
);

  always_comb begin
    o_slice = '0;
    if (i_mode10) begin
      o_slice[rxsw_pkg::POS_DATA_LSB +: rxsw_pkg::RAW_W] = i_data;
    end else begin
      o_slice[rxsw_pkg::POS_DATA_LSB +: rxsw_pkg::BYTE_W] =
        i_data[rxsw_pkg::BYTE_W-1:0];
      o_slice[rxsw_pkg::POS_CTRL]    = i_ctrl;
      o_slice[rxsw_pkg::POS_CODEERR] = i_code_err;
    end
    o_slice[rxsw_pkg::POS_SYNC]    = i_sync;
    o_slice[rxsw_pkg::POS_DISPERR] = i_disp_err;
    o_slice[rxsw_pkg::POS_PATDET]  = i_pat_det;
    if (i_pipe) begin
      o_slice[rxsw_pkg::POS_PIPE_LSB +: rxsw_pkg::PIPE_W] = i_pipe_status;
    end else begin
      o_slice[rxsw_pkg::POS_RMDEL] = i_rm_del;
      o_slice[rxsw_pkg::POS_RMINS] = i_rm_ins;
    end
    o_slice[rxsw_pkg::POS_RDISP]   = i_run_disp;
  end

endmodule // rxsw_slice_pack
`default_nettype wire

// File: rtl/rxsw_top.sv
// Purpose: receive status word packer with offset cancellation and APB registers
// Assumes: channel status inputs are synchronous to i_core_clk
// Notes: APB access phase takes two cycles, pready comes from a flip-flop
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rxsw_top #(
  parameter int unsigned SLICES     = 2,
  parameter int unsigned TOGXB_W    = 4,
  parameter int unsigned FROMGXB_W  = 5,
  parameter int unsigned CAL_CYCLES = 64
) (
  input  wire logic                                 i_core_clk,
  input  wire logic                                 i_reset,
  input  wire logic                                 i_clk_en,
  // apb slave
  input  wire logic                                 i_psel,
  input  wire logic                                 i_penable,
  input  wire logic                                 i_pwrite,
  input  wire logic [rxsw_pkg::APB_AW-1:0]          i_paddr,
  input  wire logic [31:0]                          i_pwdata,
  output logic      [31:0]                          o_prdata,
  output logic                                      o_pready,
  output logic                                      o_pslverr,
  // channel receive status per slice
  input  wire logic [SLICES*rxsw_pkg::RAW_W-1:0]    i_rx_data,
  input  wire logic [SLICES-1:0]                    i_rx_ctrl,
  input  wire logic [SLICES-1:0]                    i_rx_code_err,
  input  wire logic [SLICES-1:0]                    i_rx_sync,
  input  wire logic [SLICES-1:0]                    i_rx_disp_err,
  input  wire logic [SLICES-1:0]                    i_rx_pat_det,
  input  wire logic [SLICES-1:0]                    i_rx_rm_del,
  input  wire logic [SLICES-1:0]                    i_rx_rm_ins,
  input  wire logic [SLICES*rxsw_pkg::PIPE_W-1:0]   i_rx_pipe_status,
  input  wire logic [SLICES-1:0]                    i_rx_run_disp,
  output logic      [SLICES*rxsw_pkg::SLICE_W-1:0]  o_rx_word,
  // reconfiguration and power control
  input  wire logic                                 i_reconfig_reset,
  input  wire logic                                 i_gxb_powerdown,
  input  wire logic [FROMGXB_W-1:0]                 i_reconfig_fromgxb,
  output logic      [TOGXB_W-1:0]                   o_reconfig_togxb,
  output logic                                      o_rx_disconnect,
  output logic                                      o_oc_done
);

  localparam int unsigned WORD_W = SLICES * rxsw_pkg::SLICE_W;

  initial begin
    if (SLICES < 1 || WORD_W > 32) $error("SLICES must be 1 or 2");
    if (TOGXB_W < 1 || TOGXB_W > 32) $error("TOGXB_W out of range");
    if (FROMGXB_W < 1 || FROMGXB_W > 32) $error("FROMGXB_W out of range");
  end

  function automatic logic addr_mapped(input logic [rxsw_pkg::APB_AW-1:0] a);
    addr_mapped = (a == rxsw_pkg::OFS_CTRL)    || (a == rxsw_pkg::OFS_STATUS) ||
                  (a == rxsw_pkg::OFS_RCFGOUT) || (a == rxsw_pkg::OFS_RCFGIN) ||
                  (a == rxsw_pkg::OFS_RMCNT)   || (a == rxsw_pkg::OFS_LIVE);
  endfunction

  logic [rxsw_pkg::CTRL_W-1:0]   ctrl_reg;
  logic [TOGXB_W-1:0]            rcfg_out_reg;
  logic [FROMGXB_W-1:0]          rcfg_in_reg;
  logic                          pd_viol_reg;
  logic                          code_err_reg;
  logic                          sync_lost_reg;
  logic [rxsw_pkg::CNT_W-1:0]    ins_cnt_reg;
  logic [rxsw_pkg::CNT_W-1:0]    del_cnt_reg;
  logic [WORD_W-1:0]             word_next;
  logic [31:0]                   rdata_next;
  logic                          acc_first;
  logic                          wr_fire;
  logic                          wr_status;
  logic                          wr_rmcnt;
  logic                          oc_disconnect;
  logic                          oc_busy;
  logic                          oc_done;
  logic                          oc_start;
  logic                          mode10;
  logic                          pipe_mode;
  logic                          enable;
  logic                          any_code_err;
  logic                          any_sync_lost;
  logic                          any_ins;
  logic                          any_del;

  assign mode10    = ctrl_reg[rxsw_pkg::CTRL_MODE10];
  assign pipe_mode = ctrl_reg[rxsw_pkg::CTRL_PIPE];
  assign enable    = ctrl_reg[rxsw_pkg::CTRL_ENABLE];

  // apb handshake: first access cycle loads data, second completes
  assign acc_first = i_psel && i_penable && !o_pready;
  assign wr_fire   = i_psel && i_penable && o_pready && i_pwrite && addr_mapped(i_paddr);
  assign wr_status = wr_fire && (i_paddr == rxsw_pkg::OFS_STATUS);
  assign wr_rmcnt  = wr_fire && (i_paddr == rxsw_pkg::OFS_RMCNT);

  // slice packing
  genvar g;
  generate
    for (g = 0; g < SLICES; g++) begin : g_slice
      rxsw_slice_pack u_pack (
        .i_mode10      (mode10),
        .i_pipe        (pipe_mode),
        .i_data        (i_rx_data[g*rxsw_pkg::RAW_W +: rxsw_pkg::RAW_W]),
        .i_ctrl        (i_rx_ctrl[g]),
        .i_code_err    (i_rx_code_err[g]),
        .i_sync        (i_rx_sync[g]),
        .i_disp_err    (i_rx_disp_err[g]),
        .i_pat_det     (i_rx_pat_det[g]),
        .i_rm_del      (i_rx_rm_del[g]),
        .i_rm_ins      (i_rx_rm_ins[g]),
        .i_pipe_status (i_rx_pipe_status[g*rxsw_pkg::PIPE_W +: rxsw_pkg::PIPE_W]),
        .i_run_disp    (i_rx_run_disp[g]),
        .o_slice       (word_next[g*rxsw_pkg::SLICE_W +: rxsw_pkg::SLICE_W])
      );
    end
  endgenerate

  // whole word registered at once so data and status stay aligned
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rx_word <= '0;
    end else if (i_clk_en) begin
      if (enable) o_rx_word <= word_next;
      else o_rx_word <= '0;
    end
  end

  // offset cancellation sequencer
  rxsw_offset_cancel #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_oc (
    .i_core_clk       (i_core_clk),
    .i_reset          (i_reset),
    .i_clk_en         (i_clk_en),
    .i_reconfig_reset (i_reconfig_reset),
    .o_disconnect     (oc_disconnect),
    .o_busy           (oc_busy),
    .o_done           (oc_done),
    .o_start          (oc_start)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rx_disconnect <= 1'b0;
      o_oc_done       <= 1'b0;
    end else if (i_clk_en) begin
      o_rx_disconnect <= oc_disconnect;
      o_oc_done       <= oc_done;
    end
  end

  // reconfiguration buses: sequencer owns the outbound bus while busy
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_reconfig_togxb <= '0;
      rcfg_in_reg      <= '0;
    end else if (i_clk_en) begin
      if (oc_busy) o_reconfig_togxb <= {{(TOGXB_W-1){1'b0}}, oc_start};
      else o_reconfig_togxb <= rcfg_out_reg;
      rcfg_in_reg <= i_reconfig_fromgxb;
    end
  end

  // power-down during calibration is the far side's fault, recorded sticky
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pd_viol_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (oc_busy && i_gxb_powerdown) pd_viol_reg <= 1'b1;
      else if (wr_status && i_pwdata[rxsw_pkg::STS_PD_VIOL]) pd_viol_reg <= 1'b0;
    end
  end

  assign any_code_err  = enable && (|(i_rx_code_err & {SLICES{!mode10}}) || |i_rx_disp_err);
  assign any_sync_lost = enable && !(&i_rx_sync);
  assign any_ins       = enable && !pipe_mode && |i_rx_rm_ins;
  assign any_del       = enable && !pipe_mode && |i_rx_rm_del;

  // sticky error flags, an event beats a write-one-to-clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      code_err_reg  <= 1'b0;
      sync_lost_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (any_code_err) code_err_reg <= 1'b1;
      else if (wr_status && i_pwdata[rxsw_pkg::STS_CODE_ERR]) code_err_reg <= 1'b0;
      if (any_sync_lost) sync_lost_reg <= 1'b1;
      else if (wr_status && i_pwdata[rxsw_pkg::STS_SYNC_LOST]) sync_lost_reg <= 1'b0;
    end
  end

  // rate-match event counters, saturating, set by any write to OFS_RMCNT to zero, or to one if an event comes in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ins_cnt_reg <= rxsw_pkg::CNT_ZERO;
      del_cnt_reg <= rxsw_pkg::CNT_ZERO;
    end else if (i_clk_en) begin
      if (wr_rmcnt) begin
        ins_cnt_reg <= any_ins ? rxsw_pkg::CNT_ONE : rxsw_pkg::CNT_ZERO;
        del_cnt_reg <= any_del ? rxsw_pkg::CNT_ONE : rxsw_pkg::CNT_ZERO;
      end else begin
        if (any_ins && ins_cnt_reg != rxsw_pkg::CNT_MAX) ins_cnt_reg <= ins_cnt_reg + rxsw_pkg::CNT_ONE;
        if (any_del && del_cnt_reg != rxsw_pkg::CNT_MAX) del_cnt_reg <= del_cnt_reg + rxsw_pkg::CNT_ONE;
      end
    end
  end

  // software-writable registers
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl_reg     <= rxsw_pkg::CTRL_RESET;
      rcfg_out_reg <= '0;
    end else if (i_clk_en && wr_fire) begin
      if (i_paddr == rxsw_pkg::OFS_CTRL) ctrl_reg <= i_pwdata[rxsw_pkg::CTRL_W-1:0];
      if (i_paddr == rxsw_pkg::OFS_RCFGOUT) rcfg_out_reg <= i_pwdata[TOGXB_W-1:0];
    end
  end

  // read mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (i_paddr)
      rxsw_pkg::OFS_CTRL: begin
        rdata_next[rxsw_pkg::CTRL_W-1:0] = ctrl_reg;
      end
      rxsw_pkg::OFS_STATUS: begin
        rdata_next[rxsw_pkg::STS_OC_DONE]   = oc_done;
        rdata_next[rxsw_pkg::STS_OC_BUSY]   = oc_busy;
        rdata_next[rxsw_pkg::STS_PD_VIOL]   = pd_viol_reg;
        rdata_next[rxsw_pkg::STS_CODE_ERR]  = code_err_reg;
        rdata_next[rxsw_pkg::STS_SYNC_LOST] = sync_lost_reg;
      end
      rxsw_pkg::OFS_RCFGOUT: begin
        rdata_next[TOGXB_W-1:0] = rcfg_out_reg;
      end
      rxsw_pkg::OFS_RCFGIN: begin
        rdata_next[FROMGXB_W-1:0] = rcfg_in_reg;
      end
      rxsw_pkg::OFS_RMCNT: begin
        rdata_next[rxsw_pkg::RMCNT_INS_LSB +: rxsw_pkg::CNT_W] = ins_cnt_reg;
        rdata_next[rxsw_pkg::RMCNT_DEL_LSB +: rxsw_pkg::CNT_W] = del_cnt_reg;
      end
      rxsw_pkg::OFS_LIVE: begin
        rdata_next[WORD_W-1:0] = o_rx_word;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // apb response
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      if (acc_first) begin
        o_pready  <= 1'b1;
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rdata_next;
        o_pslverr <= !addr_mapped(i_paddr);
      end else begin
        o_pready  <= 1'b0;
        o_prdata  <= 32'h0000_0000;
        o_pslverr <= 1'b0;
      end
    end
  end

endmodule // rxsw_top
`default_nettype wire

// File: tb/rxsw_chk.sv
// Purpose: concurrent checks on receive word layout and cancellation outputs
// Assumes: i_clk_en held high; control bits mirrored from completed APB writes
// Notes: bound to rxsw_top from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module rxsw_chk #(
  parameter int unsigned SLICES     = 2,
  parameter int unsigned CAL_CYCLES = 64
) (
  input wire logic                               i_core_clk,
  input wire logic                               i_reset,
  input wire logic                               i_psel,
  input wire logic                               i_penable,
  input wire logic                               i_pwrite,
  input wire logic [rxsw_pkg::APB_AW-1:0]        i_paddr,
  input wire logic [31:0]                        i_pwdata,
  input wire logic                               o_pready,
  input wire logic                               o_pslverr,
  input wire logic [SLICES*rxsw_pkg::RAW_W-1:0]  i_rx_data,
  input wire logic [SLICES-1:0]                  i_rx_ctrl,
  input wire logic [SLICES-1:0]                  i_rx_code_err,
  input wire logic [SLICES-1:0]                  i_rx_sync,
  input wire logic [SLICES-1:0]                  i_rx_disp_err,
  input wire logic [SLICES-1:0]                  i_rx_pat_det,
  input wire logic [SLICES-1:0]                  i_rx_rm_del,
  input wire logic [SLICES-1:0]                  i_rx_rm_ins,
  input wire logic [SLICES*rxsw_pkg::PIPE_W-1:0] i_rx_pipe_status,
  input wire logic [SLICES-1:0]                  i_rx_run_disp,
  input wire logic [SLICES*rxsw_pkg::SLICE_W-1:0] o_rx_word,
  input wire logic                               i_reconfig_reset,
  input wire logic                               o_rx_disconnect,
  input wire logic                               o_oc_done
);
  logic [2:0] ctl;
  logic [7:0] dlen;
  logic       v8, v10, vp, vn;
  always_ff @(posedge i_core_clk) begin
    if (i_reset)
      ctl <= rxsw_pkg::CTRL_RESET;
    else if (i_psel && i_penable && i_pwrite && o_pready && !o_pslverr &&
             i_paddr == rxsw_pkg::OFS_CTRL)
      ctl <= i_pwdata[2:0];
  end
  // mode flags that apply to the word seen one edge later
  always_ff @(posedge i_core_clk) begin
    v8  <= !i_reset && ctl[2] && !ctl[0];
    v10 <= !i_reset && ctl[2] && ctl[0];
    vp  <= !i_reset && ctl[2] && ctl[1];
    vn  <= !i_reset && ctl[2] && !ctl[1];
  end
  always_ff @(posedge i_core_clk) begin
    if (i_reset || !o_rx_disconnect)
      dlen <= 8'h00;
    else
      dlen <= dlen + 8'h01;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_cal_end;
    $fell(o_rx_disconnect) && dlen == 8'(CAL_CYCLES + 1);
  endsequence
  chk_byte_sync: assert property (v8 |-> o_rx_word[7:0] == $past(i_rx_data[7:0]) &&
    o_rx_word[10] == $past(i_rx_sync[0])) else $error("byte or sync field wrong");
  chk_ctrl_code: assert property (v8 |->
    o_rx_word[9:8] == {$past(i_rx_code_err[0]), $past(i_rx_ctrl[0])})
    else $error("control or code flag wrong");
  chk_disp_err: assert property ((v8 || v10) |->
    o_rx_word[11] == $past(i_rx_disp_err[0])) else $error("disparity flag wrong");
  chk_raw_code: assert property (v10 |->
    o_rx_word[10:0] == {$past(i_rx_sync[0]), $past(i_rx_data[9:0])})
    else $error("raw code group wrong");
  chk_pat_rdisp: assert property ((v8 || v10) |->
    {o_rx_word[15], o_rx_word[12]} == {$past(i_rx_run_disp[0]), $past(i_rx_pat_det[0])})
    else $error("pattern or running disparity wrong");
  chk_rm_flags: assert property (vn |->
    o_rx_word[14:13] == {$past(i_rx_rm_ins[0]), $past(i_rx_rm_del[0])})
    else $error("rate match flags wrong");
  chk_pipe_stat: assert property (vp |->
    o_rx_word[14:13] == $past(i_rx_pipe_status[1:0])) else $error("pipe status wrong");
  chk_slice_one: assert property (v8 |-> o_rx_word[26:16] ==
    {$past(i_rx_sync[1]), $past(i_rx_code_err[1]), $past(i_rx_ctrl[1]),
     $past(i_rx_data[17:10])}) else $error("second slice misaligned");
  chk_done_sticky: assert property (o_oc_done |=> o_oc_done)
    else $error("cancel done dropped");
  chk_cal_length: assert property ($rose(o_oc_done) |-> s_cal_end)
    else $error("cancel length wrong");
  chk_abort_run: assert property (i_reconfig_reset && o_rx_disconnect |->
    ##[1:3] !o_rx_disconnect) else $error("cancel not abandoned");
endmodule // rxsw_chk
`default_nettype wire

// File: tb/rxsw_fabric_model.sv
// Purpose: fabric-side partner giving power-down and the inbound reconfig bus
// Assumes: same clock as the block
// Notes: power-down is withheld while the receiver is disconnected
`timescale 1ns/1ns
`default_nettype none
module rxsw_fabric_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_disconnect,
  input  wire logic       i_pd_req,
  output logic            o_powerdown,
  output logic [4:0]      o_fromgxb
);
  always_ff @(posedge i_core_clk) begin
    o_powerdown <= i_pd_req && !i_disconnect && !i_reset;
    o_fromgxb   <= i_reset ? 5'h00 : 5'h15;
  end
endmodule // rxsw_fabric_model
`default_nettype wire

// File: tb/rxsw_top_test.sv
// Purpose: self-checking bench for the receive status word block
// Assumes: two slices, short cancellation count
// Notes: APB reads and writes through one task
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module rxsw_top_test;
  localparam int unsigned SLICES = 2;
  localparam int unsigned CAL_CYCLES = 4;
  localparam logic [19:0] PT [4] = '{20'h00000, 20'hfffff, 20'haa355, 20'h55caa};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rcr = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, word, rd;
  logic [19:0] st0 = 20'h0, st1 = 20'h0;
  logic prdy, perr, dcn, done, pd, er;
  logic [3:0] tgx;
  logic [4:0] fgx;
  int fails = 0, comparisons = 0, cyc = 0;
  rxsw_top #(.SLICES(SLICES), .CAL_CYCLES(CAL_CYCLES)) u_rxsw_top (
    .i_core_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(prdy), .o_pslverr(perr), .i_rx_data({st1[9:0], st0[9:0]}),
    .i_rx_ctrl({st1[10], st0[10]}), .i_rx_code_err({st1[11], st0[11]}),
    .i_rx_sync({st1[12], st0[12]}), .i_rx_disp_err({st1[13], st0[13]}),
    .i_rx_pat_det({st1[14], st0[14]}), .i_rx_rm_del({st1[15], st0[15]}),
    .i_rx_rm_ins({st1[16], st0[16]}), .i_rx_run_disp({st1[17], st0[17]}),
    .i_rx_pipe_status({st1[19:18], st0[19:18]}), .o_rx_word(word),
    .i_reconfig_reset(rcr), .i_gxb_powerdown(pd), .i_reconfig_fromgxb(fgx),
    .o_reconfig_togxb(tgx), .o_rx_disconnect(dcn), .o_oc_done(done));
  rxsw_fabric_model u_rxsw_fabric_model (.i_core_clk(clk), .i_reset(rst),
    .i_disconnect(dcn), .i_pd_req(1'b0), .o_powerdown(pd), .o_fromgxb(fgx));
  always #50 clk = ~clk;
  task automatic conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] ex(input logic [2:0] c, input logic [19:0] s);
    logic [15:0] w;
    w = 16'h0;
    if (c[2]) begin
      w = {s[17], c[1] ? s[19:18] : s[16:15], s[14], s[13], s[12], 2'b00, s[7:0]};
      w[9:0] = c[0] ? s[9:0] : {s[11:10], s[7:0]};
    end
    return w;
  endfunction
  task automatic t_regs;
    apb(1'b0, rxsw_pkg::OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h4, rd)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
  endtask
  task automatic t_cancel;
    int n;
    repeat (4) @(negedge clk);
    `CHK("held in reset", 1'b0, dcn)
    @(posedge clk);
    rcr <= 1'b0;
    for (n = 0; n < 10 && !dcn; n++) @(negedge clk);
    `CHK("started", 1'b1, dcn)
    `CHK("togxb start", 4'h1, tgx)
    @(posedge clk);
    rcr <= 1'b1;
    repeat (4) @(negedge clk);
    `CHK("abandoned", 2'b00, {dcn, done})
    @(posedge clk);
    rcr <= 1'b0;
    for (n = 0; n < 40 && !done; n++) @(negedge clk);
    `CHK("done", 1'b1, done)
    @(posedge clk);
    rcr <= 1'b1;
    repeat (3) @(posedge clk);
    rcr <= 1'b0;
    repeat (12) begin
      @(negedge clk);
      `CHK("no rerun", 2'b01, {dcn, done})
    end
    // sync still low on every slice, so the sticky bit survives its clear
    apb(1'b1, rxsw_pkg::OFS_STATUS, 32'h1c);
    apb(1'b0, rxsw_pkg::OFS_STATUS, 32'h0);
    `CHK("status", 32'h11, rd)
  endtask
  task automatic t_words;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, rxsw_pkg::OFS_CTRL, 32'(c));
      for (int p = 0; p < 4; p++) begin
        @(posedge clk);
        st0 <= PT[p];
        st1 <= PT[p] ^ 20'h0f0f0;
        @(posedge clk);
        @(negedge clk);
        `CHK("word", {ex(3'(c), PT[p] ^ 20'h0f0f0), ex(3'(c), PT[p])}, word)
      end
    end
  endtask
  task automatic t_reconfig;
    apb(1'b0, rxsw_pkg::OFS_LIVE, 32'h0);
    `CHK("live", {ex(3'h7, PT[3] ^ 20'h0f0f0), ex(3'h7, PT[3])}, rd)
    apb(1'b1, rxsw_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, rxsw_pkg::OFS_STATUS, 32'h1c);
    apb(1'b0, rxsw_pkg::OFS_STATUS, 32'h0);
    `CHK("status clear", 32'h1, rd)
    apb(1'b1, rxsw_pkg::OFS_RCFGOUT, 32'ha);
    repeat (2) @(negedge clk);
    `CHK("togxb", 4'ha, tgx)
    apb(1'b0, rxsw_pkg::OFS_RCFGIN, 32'h0);
    `CHK("fromgxb", 32'h15, rd)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_cancel();
    t_words();
    t_reconfig();
    conclude();
  end
endmodule // rxsw_top_test
bind rxsw_top rxsw_chk #(.SLICES(SLICES), .CAL_CYCLES(CAL_CYCLES)) u_rxsw_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_rx_data(i_rx_data), .i_rx_ctrl(i_rx_ctrl),
  .i_rx_code_err(i_rx_code_err), .i_rx_sync(i_rx_sync), .i_rx_disp_err(i_rx_disp_err),
  .i_rx_pat_det(i_rx_pat_det), .i_rx_rm_del(i_rx_rm_del), .i_rx_rm_ins(i_rx_rm_ins),
  .i_rx_pipe_status(i_rx_pipe_status), .i_rx_run_disp(i_rx_run_disp),
  .o_rx_word(o_rx_word), .i_reconfig_reset(i_reconfig_reset),
  .o_rx_disconnect(o_rx_disconnect), .o_oc_done(o_oc_done));
`default_nettype wire
